// ### design/see_map.svh
// Constants for the serial EEPROM command and array-access block.
// Assumes inclusion by bare name from the design files.
`ifndef SEE_MAP_SVH
`define SEE_MAP_SVH

// Command opcodes
`define SEE_OP_SETL 8'h06
`define SEE_OP_CLRL 8'h04
`define SEE_OP_SRD 8'h05
`define SEE_OP_SWR 8'h01
`define SEE_OP_READ 8'h03
`define SEE_OP_WRITE 8'h02

// Status register bit positions
`define SEE_SB_PGE 7
`define SEE_SB_IPS 6
`define SEE_SB_ZERO 5
`define SEE_SB_LOCK 4
`define SEE_SB_GHI 3
`define SEE_SB_GLO 2
`define SEE_SB_LATCH 1
`define SEE_SB_BUSY 0
`define SEE_SR_RST 8'h00
`define SEE_SW_MASK 8'hDC

// Block guard region starts
`define SEE_QTR_BASE 17'h18000
`define SEE_HALF_BASE 17'h10000

// Byte counter stages in a frame
`define SEE_NB_OP 3'h1
`define SEE_NB_STAT 3'h2
`define SEE_NB_ADDR 3'h4
`define SEE_NB_DATA 3'h5

// Self-timed write cycle
`define SEE_WC_NS 5000000
`define SEE_CLK_NS 40
`define SEE_WC_CYC (`SEE_WC_NS / `SEE_CLK_NS)
`define SEE_PAGE_LAST 17'h000FF

`endif

// ### design/see_pkg.sv
// Types shared by the serial EEPROM access block.
// Assumes nothing beyond a SystemVerilog compiler.
package see_pkg;
    typedef logic [7:0] see_byte_type;
    typedef logic [16:0] see_addr_type;
    typedef enum logic {SEE_IDLE, SEE_PROG} see_state_type;
endpackage

// ### design/see_access.sv
// Serial EEPROM command decode, protection and array access.
// Assumes an SPI host in mode 0 or 3 driving sck_i, cs_n_i and si_i.
`include "see_map.svh"

module see_access #(
    parameter int unsigned WC_CYCLES = `SEE_WC_CYC
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    input wire logic protect_pin_n_i,
    output logic so_o,
    output logic so_oe_o,
    output see_pkg::see_byte_type status_o,
    output logic busy_o
);
    import see_pkg::*;

    function automatic logic guard_hit(input logic hi, input logic lo,
                                       input see_addr_type a);
        logic hit;
        hit = 1'b0;
        case ({hi, lo})
            2'b00: hit = 1'b0;
            2'b01: hit = (a >= `SEE_QTR_BASE);
            2'b10: hit = (a >= `SEE_HALF_BASE);
            default: hit = 1'b1;
        endcase
        return hit;
    endfunction

    logic [7:0] mem [0:131071];
    logic [7:0] idm [0:255];
    logic [7:0] pbuf [0:255];
    logic [255:0] mask_q;

    // Link side, runs only while the host clocks a frame
    logic ign_q, rd_mode_q, st_mode_q, wid_q;
    // No reset reaches the link side; start levels match the idle frame
    logic fresh_q = 1'b1;
    logic seq_q = 1'b0;
    logic [2:0] bcnt_q, nb_q;
    logic [7:0] sh_q, op_q, tx_q, sdat_q, wlo_q;
    logic [15:0] ad_q;
    logic [8:0] pg_q;
    see_addr_type rd_ptr_q;
    see_byte_type st_s1, st_s2;
    logic so_q;

    // Select high ends the frame; sck has no edge then
    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            fresh_q <= 1'b1;
        end else begin
            fresh_q <= 1'b0;
        end
    end

    wire [2:0] bcnt_cur = fresh_q ? 3'h0 : bcnt_q;
    wire [2:0] nb_cur = fresh_q ? 3'h0 : nb_q;
    wire [7:0] byte_w = {sh_q[6:0], si_i};
    wire byte_end = (bcnt_cur == 3'h7);
    wire op_end = byte_end && (nb_cur == 3'h0);
    wire addr_end = byte_end && (nb_cur == 3'h3);
    wire data_end = byte_end && (nb_cur >= `SEE_NB_ADDR);
    wire [2:0] nb_d = (byte_end && nb_cur != `SEE_NB_DATA) ?
                      nb_cur + 3'h1 : nb_cur;
    wire busy_l = st_s2[`SEE_SB_BUSY];
    wire ips_l = st_s2[`SEE_SB_IPS];
    wire ign_d = busy_l && (byte_w != `SEE_OP_SRD);
    wire [7:0] op_cur = op_end ? byte_w : op_q;
    wire ign_cur = op_end ? ign_d : ign_q;
    wire live = !ign_cur;
    wire srd_go = op_end && (byte_w == `SEE_OP_SRD);
    wire rd_go = addr_end && (op_cur == `SEE_OP_READ) && live;
    wire rd_act = rd_mode_q && !fresh_q;
    wire st_act = st_mode_q && !fresh_q;
    wire wr_act = (op_cur == `SEE_OP_WRITE) && live && !fresh_q;
    wire see_addr_type addr_w = {ad_q[8:0], byte_w};
    wire see_addr_type rsel = addr_end ? addr_w : rd_ptr_q;
    wire [7:0] rdat = ips_l ? idm[rsel[7:0]] : mem[rsel];
    wire load_rd = rd_go || (byte_end && rd_act);
    wire load_st = srd_go || (byte_end && st_act);

    always_ff @(posedge sck_i) begin
        sh_q <= byte_w;
        bcnt_q <= bcnt_cur + 3'h1;
        nb_q <= nb_d;
        st_s1 <= status_o;
        st_s2 <= st_s1;
        rd_mode_q <= rd_go || rd_act;
        st_mode_q <= srd_go || st_act;
        if (fresh_q) begin
            seq_q <= ~seq_q;
        end
        if (op_end) begin
            op_q <= byte_w;
            ign_q <= ign_d;
        end
        if (byte_end && (nb_cur == 3'h1 || nb_cur == 3'h2)) begin
            ad_q <= {ad_q[7:0], byte_w};
        end
        if (byte_end && nb_cur == `SEE_NB_OP && op_q == `SEE_OP_SWR) begin
            sdat_q <= byte_w;
        end
        if (load_st) begin
            tx_q <= st_s2;
        end else if (load_rd) begin
            tx_q <= rdat;
        end else begin
            tx_q <= {tx_q[6:0], 1'b0};
        end
        if (load_rd) begin
            rd_ptr_q <= rsel + 17'h00001;
        end
    end

    // Page buffer fill; the low byte wraps so the page address holds
    always_ff @(posedge sck_i) begin
        if (addr_end && wr_act) begin
            wlo_q <= byte_w;
            pg_q <= ad_q[8:0];
            wid_q <= ips_l;
            mask_q <= '0;
        end else if (data_end && wr_act) begin
            pbuf[wlo_q] <= byte_w;
            mask_q[wlo_q] <= 1'b1;
            wlo_q <= wlo_q + 8'h01;
        end
    end

    always_ff @(negedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            so_q <= 1'b0;
        end else begin
            so_q <= tx_q[7];
        end
    end

    assign so_o = so_q;
    assign so_oe_o = !cs_n_i && (rd_act || st_act);

    // System clock side
    see_state_type state_q;
    logic [1:0] cs_s, wp_s;
    logic cs_r, wp_r, seen_q, latch_q, wp_fell_q, pmem_q, pid_q;
    logic [7:0] sr_q;
    logic [16:0] cnt_q;

    always_ff @(posedge clk_i) begin
        cs_s <= {cs_s[0], cs_n_i};
        wp_s <= {wp_s[0], protect_pin_n_i};
        cs_r <= cs_s[1];
        wp_r <= wp_s[1];
    end

    // Frame fields are held quiet by the host while select is high
    wire cs_rise = cs_s[1] && !cs_r;
    wire new_frame = cs_rise && (seq_q != seen_q);
    wire idle = (state_q == SEE_IDLE);
    wire whole = (bcnt_q == 3'h0);
    wire base_ok = new_frame && !ign_q && idle;
    wire pge = sr_q[`SEE_SB_PGE];
    wire ghi = sr_q[`SEE_SB_GHI];
    wire glo = sr_q[`SEE_SB_GLO];
    wire lock = sr_q[`SEE_SB_LOCK];
    wire pin_block = pge && (!wp_s[1] || wp_fell_q);
    wire setl_go = base_ok && op_q == `SEE_OP_SETL &&
                   nb_q == `SEE_NB_OP && whole;
    wire clrl_go = base_ok && op_q == `SEE_OP_CLRL &&
                   nb_q != 3'h0;
    wire sw_go = base_ok && op_q == `SEE_OP_SWR && nb_q >= `SEE_NB_STAT &&
                 whole && latch_q && !pin_block;
    wire id_ok = !lock && !(ghi && glo);
    wire pg_ok = !guard_hit(ghi, glo, {pg_q, 8'h00});
    wire mw_go = base_ok && op_q == `SEE_OP_WRITE &&
                 nb_q == `SEE_NB_DATA && whole && latch_q &&
                 (wid_q ? id_ok : pg_ok);
    wire last_cyc = (cnt_q == 17'(WC_CYCLES - 1));
    wire prog_end = !idle && last_cyc;
    wire [7:0] idx = cnt_q[7:0];
    wire in_page = (cnt_q <= `SEE_PAGE_LAST);
    wire id_blk = guard_hit(ghi, glo, {9'h000, idx});
    wire wr_en = !idle && pmem_q && in_page && mask_q[idx] &&
                 !(pid_q && id_blk);
    wire both_set = sdat_q[`SEE_SB_IPS] && sdat_q[`SEE_SB_LOCK];
    wire [7:0] keep = both_set ? 8'h50 : 8'h00;
    wire [7:0] wmask = `SEE_SW_MASK & ~keep;
    wire [7:0] sr_keep = (sr_q & ~wmask) | (sdat_q & wmask);
    // Lock is one-way: a zero written to it never unlocks the id page
    wire [7:0] sr_new = sr_keep | {3'h0, lock, 4'h0};

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            state_q <= SEE_IDLE;
            cnt_q <= 17'h00000;
            seen_q <= 1'b0;
            latch_q <= 1'b0;
            wp_fell_q <= 1'b0;
            pmem_q <= 1'b0;
            pid_q <= 1'b0;
            sr_q <= `SEE_SR_RST;
        end else begin
            if (cs_rise) begin
                seen_q <= seq_q;
            end
            if (wp_r && !wp_s[1] && !cs_s[1]) begin
                wp_fell_q <= 1'b1;
            end else if (cs_rise) begin
                wp_fell_q <= 1'b0;
            end
            if (setl_go) begin
                latch_q <= 1'b1;
            end else if (clrl_go || prog_end) begin
                latch_q <= 1'b0;
            end
            if (sw_go) begin
                sr_q <= sr_new;
            end else if (prog_end && pmem_q && pid_q) begin
                sr_q[`SEE_SB_IPS] <= 1'b0;
            end
            unique case (state_q)
                SEE_IDLE: begin
                    cnt_q <= 17'h00000;
                    if (sw_go || mw_go) begin
                        state_q <= SEE_PROG;
                        pmem_q <= mw_go;
                        pid_q <= wid_q;
                    end
                end
                SEE_PROG: begin
                    cnt_q <= cnt_q + 17'h00001;
                    if (last_cyc) begin
                        state_q <= SEE_IDLE;
                    end
                end
            endcase
        end
    end

    // Array contents are not reset, as in the nonvolatile part
    always_ff @(posedge clk_i) begin
        if (wr_en && pid_q) begin
            idm[idx] <= pbuf[idx];
        end else if (wr_en) begin
            mem[{pg_q, idx}] <= pbuf[idx];
        end
    end

    assign busy_o = !idle;
    assign status_o = {sr_q[7:6], 1'b0, sr_q[4:2], latch_q, busy_o};

    // Checks
    a_latch_gates_prog: assert property (@(posedge clk_i)
        disable iff (!rst_b_i) $rose(busy_o) |-> $past(latch_q))
        else $error("Write cycle started without the latch");
    a_busy_holds: assert property (@(posedge clk_i)
        disable iff (!rst_b_i) $rose(busy_o) |-> status_o[0] [*8])
        else $error("Busy flag dropped early");
    a_latch_autoclear: assert property (@(posedge clk_i)
        disable iff (!rst_b_i) $fell(busy_o) |-> !status_o[1])
        else $error("Latch still set after write cycle");
    a_guard_never_hit: assert property (@(posedge clk_i)
        disable iff (!rst_b_i) (wr_en && !pid_q) |->
            !guard_hit(ghi, glo, {pg_q, idx}))
        else $error("Guarded block written");
    a_bit5_zero: assert property (@(posedge clk_i)
        disable iff (!rst_b_i) !status_o[5] && status_o[0] == busy_o)
        else $error("Status layout broken");
    a_pin_refuses: assert property (@(posedge clk_i)
        disable iff (!rst_b_i) (new_frame && op_q == `SEE_OP_SWR &&
            idle && pge && !wp_s[1]) |=> !busy_o)
        else $error("Status write passed the pin guard");
    a_id_lock_held: assert property (@(posedge clk_i)
        disable iff (!rst_b_i) (wr_en && pid_q) |-> !lock)
        else $error("Locked id page written");
    a_latch_set: assert property (@(posedge clk_i)
        disable iff (!rst_b_i) setl_go |=> status_o[1] ##1 status_o[1])
        else $error("Latch not set");
    a_latch_clear: assert property (@(posedge clk_i)
        disable iff (!rst_b_i) clrl_go |=> !status_o[1])
        else $error("Latch not cleared");
    a_status_mask: assert property (@(posedge clk_i)
        disable iff (!rst_b_i) sw_go |=>
            (status_o[1:0] == 2'b11) && (sr_q[5] == $past(sr_q[5])))
        else $error("Status write touched fixed bits");
    a_busy_ignores: assert property (@(posedge sck_i)
        disable iff (cs_n_i) (op_end && busy_l &&
            byte_w != `SEE_OP_SRD) |=> ign_q)
        else $error("Command taken while busy");

    // Cycle count, window, guard, lock, latch, pin and output checks
    a_busy_start: assert property (@(posedge clk_i)
        disable iff (!rst_b_i) $rose(busy_o) |-> cnt_q == 17'h00000)
        else $error("Write cycle counter not cleared at start");
    a_busy_length: assert property (@(posedge clk_i)
        disable iff (!rst_b_i) $fell(busy_o) |-> cnt_q == 17'(WC_CYCLES))
        else $error("Write cycle ended at wrong count");
    a_prog_when_idle: assert property (@(posedge clk_i)
        disable iff (!rst_b_i) (sw_go || mw_go) |-> !busy_o)
        else $error("Write accepted while busy");
    a_whole_bytes: assert property (@(posedge clk_i)
        disable iff (!rst_b_i) mw_go |-> bcnt_q == 3'h0)
        else $error("Write started after a partial byte");
    a_page_window: assert property (@(posedge clk_i)
        disable iff (!rst_b_i) wr_en |-> cnt_q < 17'h00100)
        else $error("Array written outside the page window");
    a_full_guard_id: assert property (@(posedge clk_i)
        disable iff (!rst_b_i) (wr_en && pid_q) |-> !(ghi && glo))
        else $error("Id page written under full guard");
    a_id_sel_clears: assert property (@(posedge clk_i)
        disable iff (!rst_b_i) ($fell(busy_o) && $past(pid_q && pmem_q))
            |-> !status_o[6])
        else $error("Id page select kept after id write");
    a_lock_sticky: assert property (@(posedge clk_i)
        disable iff (!rst_b_i) $past(lock) |-> lock)
        else $error("Id page lock cleared");
    a_so_quiet: assert property (@(posedge clk_i)
        disable iff (!rst_b_i) cs_n_i |-> !so_o && !so_oe_o)
        else $error("Data out driven while deselected");
    a_fixed_bits: assert property (@(posedge clk_i)
        disable iff (!rst_b_i) sw_go |=>
            !status_o[5] && sr_q[1:0] == $past(sr_q[1:0]))
        else $error("Status write touched bits 0, 1 or 5");
    a_latch_for_sw: assert property (@(posedge clk_i)
        disable iff (!rst_b_i) sw_go |-> latch_q)
        else $error("Status write without the latch");
    a_pin_gate: assert property (@(posedge clk_i)
        disable iff (!rst_b_i) sw_go |-> !pge || (wp_s[1] && !wp_fell_q))
        else $error("Status write passed a low protect pin");
    a_setl_idle: assert property (@(posedge clk_i)
        disable iff (!rst_b_i) setl_go |-> !busy_o)
        else $error("Latch set while busy");
    a_wp_abort: assert property (@(posedge clk_i)
        disable iff (!rst_b_i) (new_frame && op_q == `SEE_OP_SWR &&
            idle && pge && wp_fell_q) |=> !busy_o)
        else $error("Status write kept after pin fell");
    a_status_shift: assert property (@(posedge sck_i)
        disable iff (cs_n_i) srd_go |=> st_mode_q)
        else $error("Status read output not started");
    a_read_start: assert property (@(posedge sck_i)
        disable iff (cs_n_i) rd_go |=> rd_mode_q)
        else $error("Array read output not started");
endmodule

// ### tb/see_host.sv
// SPI host model: frames of bits on cs_n, sck, si; samples so.
// Assumes mode 0 and a caller that leaves cs high between frames.
module see_host (
    output logic cs_n_o,
    output logic sck_o,
    output logic si_o,
    input wire logic so_i
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b0;
    end
    // Clock idles low between frames; si toggles when not meaningful
    task automatic xfer(input logic [7:0] tx[$], input int nb, input int nr,
                        output logic [7:0] rx[$]);
        logic [7:0] b;
        int i;
        rx = {};
        b = 8'h00;
        cs_n_o = 1'b0;
        for (i = 0; i < nb + nr * 8; i++) begin
            si_o = (i < nb) ? tx[i / 8][7 - i % 8] : ~si_o;
            #15 sck_o = 1'b1;
            if (i >= nb) begin
                b = {b[6:0], so_i};
                if ((i - nb) % 8 == 7) begin
                    rx.push_back(b);
                end
            end
            #15 sck_o = 1'b0;
        end
        #15 cs_n_o = 1'b1;
        si_o = ~si_o;
        #200;
    endtask
endmodule

// ### tb/tb_top.sv
// Bench for the serial EEPROM access block with a memory model.
// Assumes see_host drives the link at 30 ns per serial bit.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import see_pkg::*;
    localparam int unsigned WC = 300;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic pin_n = 1'b1;
    logic sck, cs_n, si, so, so_oe, busy;
    see_byte_type status;
    int fails = 0;
    int n_tests = 0;
    logic [31:0] seed = 32'd99;
    logic [7:0] mem [int];
    logic [7:0] idp [int];
    logic idsel = 1'b0;
    logic [7:0] tx[$];
    logic [7:0] rx[$];
    logic [23:0] a;
    always #20 clk_i = ~clk_i;
    see_access #(.WC_CYCLES(WC)) see_access_inst (.clk_i(clk_i),
        .rst_b_i(rst_b_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
        .protect_pin_n_i(pin_n), .so_o(so), .so_oe_o(so_oe),
        .status_o(status), .busy_o(busy));
    see_host see_host_inst (.cs_n_o(cs_n), .sck_o(sck), .si_o(si),
        .so_i(so));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic frame(input int nb, input int nr);
        see_host_inst.xfer(tx, nb, nr, rx);
        @(negedge clk_i);
    endtask
    task automatic cmd(input logic [7:0] op);
        tx = {op};
        frame(8, 0);
    endtask
    // Model updated only where the write is expected to land
    task automatic wr(input logic [23:0] ad, input int n, input int ex,
                      input logic ok);
        logic [7:0] d;
        int k;
        tx = {8'h02, ad[23:16], ad[15:8], ad[7:0]};
        for (k = 0; k < n + (ex > 0); k++) begin
            d = xs();
            tx.push_back(d);
            if (ok && idsel) begin
                idp[int'(8'(ad[7:0] + k))] = d;
            end else if (ok) begin
                mem[int'({ad[16:8], 8'(ad[7:0] + k)})] = d;
            end
        end
        frame(32 + 8 * n + ex, 0);
        check({7'h00, busy}, {7'h00, ok});
    endtask
    task automatic rd(input logic [23:0] ad, input int n);
        int k;
        tx = {8'h03, ad[23:16], ad[15:8], ad[7:0]};
        frame(32, n);
        for (k = 0; k < n; k++) begin
            if (idsel) begin
                check(rx[k], idp[int'(8'(ad[7:0] + k))]);
            end else begin
                check(rx[k], mem[int'(see_addr_type'(ad + k))]);
            end
        end
    endtask
    task automatic idle();
        int i;
        for (i = 0; i < WC + 50 && busy === 1'b1; i++) begin
            @(negedge clk_i);
        end
        if (busy !== 1'b0) begin
            fails++;
            summarize();
        end
    endtask
    task automatic sw(input logic [7:0] v, input logic ok);
        tx = {8'h01, v};
        frame(16, 0);
        check({7'h00, busy}, {7'h00, ok});
        idle();
    endtask
    initial begin
        repeat (2) @(negedge clk_i);
        rst_b_i = 1'b1;
        repeat (3) @(negedge clk_i);
        check(status, 8'h00);
        a = 24'(xs());
        wr(a, 1, 0, 1'b0);
        tx = {8'h06, 8'h00};
        frame(16, 0);
        check(status, 8'h00);
        cmd(8'h06);
        check(status, 8'h02);
        cmd(8'h04);
        check(status, 8'h00);
        cmd(8'h06);
        a = {16'(xs() >> 8), 8'hFE};
        wr(a, 4, 0, 1'b1);
        tx = {8'h05};
        frame(8, 1);
        check(rx[0], 8'h03);
        cmd(8'h04);
        cmd(8'h05);
        check(status, 8'h03);
        idle();
        check(status, 8'h00);
        rd({~a[23:17], a[16:0]}, 2);
        rd({a[23:8], 8'h00}, 2);
        cmd(8'h06);
        wr(a, 1, 3, 1'b0);
        check(status, 8'h02);
        sw(8'hAF, 1'b1);
        check(status, 8'h8C);
        cmd(8'h06);
        wr(24'h000010, 1, 0, 1'b0);
        pin_n = 1'b0;
        sw(8'h00, 1'b0);
        check(status, 8'h8E);
        pin_n = 1'b1;
        sw(8'h00, 1'b1);
        pin_n = 1'b0;
        cmd(8'h06);
        sw(8'h04, 1'b1);
        check(status, 8'h04);
        cmd(8'h06);
        wr(24'h018000, 1, 0, 1'b0);
        wr(24'h017FFF, 1, 0, 1'b1);
        idle();
        rd(24'h017FFF, 1);
        idsel = 1'b1;
        cmd(8'h06);
        sw(8'h44, 1'b1);
        check(status, 8'h44);
        cmd(8'h06);
        wr(24'hFEDC10, 2, 0, 1'b1);
        idle();
        check(status, 8'h04);
        cmd(8'h06);
        sw(8'h54, 1'b1);
        check(status, 8'h04);
        cmd(8'h06);
        sw(8'h14, 1'b1);
        cmd(8'h06);
        sw(8'h44, 1'b1);
        check(status, 8'h54);
        cmd(8'h06);
        wr(24'h000030, 1, 0, 1'b0);
        rd(24'hFEDC10, 2);
        pin_n = 1'b1;
        cmd(8'h06);
        sw(8'hD4, 1'b1);
        cmd(8'h06);
        fork
            #300 pin_n = 1'b0;
            sw(8'h54, 1'b0);
        join
        check(status, 8'hD6);
        summarize();
    end
endmodule
